// *** verilog/rtc_alarm_pkg.sv ***
// Package for the calendar clock alarm, carry and interrupt block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`default_nettype none
package rtc_alarm_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FLAG_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PERIOD_CTRL = 8'h04;
  localparam logic [7:0] OFF_YEAR_CTRL   = 8'h08;
  localparam logic [7:0] OFF_SEC_ALARM   = 8'h0c;
  localparam logic [7:0] OFF_MIN_ALARM   = 8'h10;
  localparam logic [7:0] OFF_HR_ALARM    = 8'h14;
  localparam logic [7:0] OFF_WK_ALARM    = 8'h18;
  localparam logic [7:0] OFF_DAY_ALARM   = 8'h1c;
  localparam logic [7:0] OFF_MON_ALARM   = 8'h20;
  localparam logic [7:0] OFF_YR_ALARM    = 8'h24;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CARRY_FLAG  = 7;
  localparam int BIT_CARRY_IE    = 4;
  localparam int BIT_CARRY_READY = 3;
  localparam int BIT_ALARM_IE    = 3 - 3 + 1;
  localparam int BIT_ALARM_FLAG  = 0;
  localparam int BIT_PERIOD_FLAG = 7;
  localparam int BIT_FIELD_EN    = 7;
  localparam int BIT_YEAR_EN     = 7;
  localparam logic [2:0] PERIOD_OFF = 3'h0;
  localparam logic [7:0] PERIOD_CTRL_RESET = 8'h00;
  // Time counter snapshot carried as one bundle
  typedef struct packed {
    logic [15:0] year;
    logic [7:0]  mon;
    logic [7:0]  day;
    logic [7:0]  wk;
    logic [7:0]  hr;
    logic [7:0]  min;
    logic [7:0]  sec;
  } time_t;
endpackage
`default_nettype wire

// *** verilog/rtc_alarm_carry_irq.sv ***
// Alarm compare, carry status and interrupt requests of a calendar clock.
// Assumes counters run elsewhere and report carries and periodic ticks as pulses.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_carry_irq (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire rtc_alarm_pkg::time_t time_count,
  input  wire logic                 carry_event,
  input  wire logic                 carry_ready,
  input  wire logic                 period_tick,
  output logic                      counter_write,
  output logic                      alarm_irq_request,
  output logic                      periodic_irq_request,
  output logic                      carry_irq_request
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        carry_flag;
  logic        alarm_flag;
  logic        periodic_flag;
  logic        carry_irq_enable;
  logic        alarm_irq_enable;
  logic [2:0]  periodic_interval_select;
  logic [4:0]  period_other_reg;
  logic        year_alarm_enable;
  logic [7:0]  alarm_field_reg [6];
  logic [15:0] year_alarm_reg;
  logic        wr;
  logic        rd;
  logic        match;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;

  // One strobe per flag-holding control register keeps the flag clear terms short
  logic flag_ctrl_wr;
  logic period_ctrl_wr;
  assign flag_ctrl_wr   = wr & (paddr == rtc_alarm_pkg::OFF_FLAG_CTRL);
  assign period_ctrl_wr = wr & (paddr == rtc_alarm_pkg::OFF_PERIOD_CTRL);

  // Field compare: a disabled field counts as matching
  function automatic logic field_ok(input logic [7:0] alarm, input logic [7:0] count);
    field_ok = ~alarm[rtc_alarm_pkg::BIT_FIELD_EN] | (alarm[6:0] == count[6:0]);
  endfunction

  // Byte offset of alarm field idx; shared by the write and the read decode
  function automatic logic [7:0] alarm_offset(input int idx);
    alarm_offset = rtc_alarm_pkg::OFF_SEC_ALARM + 8'(4 * idx);
  endfunction

  // ----------------------------------------------------------------
  // Alarm compare
  // ----------------------------------------------------------------
  // Per-field results kept apart so a miss can be traced to its field
  logic [6:0] field_hit;
  logic       any_enabled;

  // A disabled field counts as matching; the year has its own enable
  always_comb begin
    field_hit[0] = field_ok(alarm_field_reg[0], time_count.sec);
    field_hit[1] = field_ok(alarm_field_reg[1], time_count.min);
    field_hit[2] = field_ok(alarm_field_reg[2], time_count.hr);
    field_hit[3] = field_ok(alarm_field_reg[3], time_count.wk);
    field_hit[4] = field_ok(alarm_field_reg[4], time_count.day);
    field_hit[5] = field_ok(alarm_field_reg[5], time_count.mon);
    field_hit[6] = ~year_alarm_enable | (year_alarm_reg == time_count.year);
  end

  // Needs at least one enabled field, or an empty alarm would fire forever
  always_comb begin
    any_enabled = year_alarm_enable;
    for (int i = 0; i < 6; i++)
      any_enabled = any_enabled | alarm_field_reg[i][rtc_alarm_pkg::BIT_FIELD_EN];
  end

  // Every field must agree in the same cycle
  assign match = (&field_hit) & any_enabled;

  // ----------------------------------------------------------------
  // Flags: hardware set wins over a software clear in the same cycle
  // ----------------------------------------------------------------
  // Alarm flag re-sets while the match holds, so a clear sticks only once time moves on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_flag <= 1'b0;
    end else if (match) begin
      alarm_flag <= 1'b1;
    end else if (flag_ctrl_wr && !pwdata[rtc_alarm_pkg::BIT_ALARM_FLAG]) begin
      alarm_flag <= 1'b0;
    end
  end

  // A carry that meets a clear still sets the flag, so software sees the collision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_flag <= 1'b0;
    end else if (carry_event) begin
      carry_flag <= 1'b1;
    end else if (flag_ctrl_wr && !pwdata[rtc_alarm_pkg::BIT_CARRY_FLAG]) begin
      carry_flag <= 1'b0;
    end
  end

  // Periodic flag is set by every tick; the interval select only gates the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_flag <= 1'b0;
    end else if (period_tick) begin
      periodic_flag <= 1'b1;
    end else if (period_ctrl_wr && !pwdata[rtc_alarm_pkg::BIT_PERIOD_FLAG]) begin
      periodic_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_irq_enable         <= 1'b0;
      alarm_irq_enable         <= 1'b0;
      periodic_interval_select <= rtc_alarm_pkg::PERIOD_CTRL_RESET[6:4];
      period_other_reg         <= rtc_alarm_pkg::PERIOD_CTRL_RESET[4:0];
      year_alarm_enable        <= 1'b0;
    end else if (wr) begin
      case (paddr)
        rtc_alarm_pkg::OFF_FLAG_CTRL: begin
          carry_irq_enable <= pwdata[rtc_alarm_pkg::BIT_CARRY_IE];
          alarm_irq_enable <= pwdata[rtc_alarm_pkg::BIT_ALARM_IE];
        end
        rtc_alarm_pkg::OFF_PERIOD_CTRL: begin
          periodic_interval_select <= pwdata[6:4];
          period_other_reg         <= pwdata[4:0];
        end
        rtc_alarm_pkg::OFF_YEAR_CTRL: year_alarm_enable <= pwdata[rtc_alarm_pkg::BIT_YEAR_EN];
        default: ;
      endcase
    end
  end

  // Alarm values; enables clear at reset so no alarm fires before setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++)
        alarm_field_reg[i] <= 8'h00;
      year_alarm_reg <= 16'h0000;
    end else if (wr) begin
      for (int i = 0; i < 6; i++)
        if (paddr == alarm_offset(i))
          alarm_field_reg[i] <= pwdata[7:0];
      if (paddr == rtc_alarm_pkg::OFF_YR_ALARM)
        year_alarm_reg <= pwdata[15:0];
    end
  end

  // Counter write strobe is tied low at all times; the carry term has no effect on it
  assign counter_write = 1'b0 & ~carry_event;

  // ----------------------------------------------------------------
  // Read data and error answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        rtc_alarm_pkg::OFF_FLAG_CTRL:
          prdata[7:0] <= {carry_flag, 2'h0, carry_irq_enable, carry_ready, 1'b0, alarm_irq_enable, alarm_flag};
        rtc_alarm_pkg::OFF_PERIOD_CTRL:
          prdata[7:0] <= {periodic_flag, periodic_interval_select, period_other_reg[3:0]};
        rtc_alarm_pkg::OFF_YEAR_CTRL: prdata[7:0] <= {year_alarm_enable, 7'h00};
        rtc_alarm_pkg::OFF_YR_ALARM:  prdata[15:0] <= year_alarm_reg;
        default: begin
          for (int i = 0; i < 6; i++)
            if (paddr == alarm_offset(i))
              prdata[7:0] <= alarm_field_reg[i];
        end
      endcase
    end
  end

  // Unmapped or unaligned addresses answer with an error
  assign pslverr = psel & penable & ((paddr[1:0] != 2'h0) | (paddr > rtc_alarm_pkg::OFF_YR_ALARM));

  // ----------------------------------------------------------------
  // Interrupt requests, purely combinational so they drop with the clear
  // ----------------------------------------------------------------
  assign alarm_irq_request    = alarm_flag & alarm_irq_enable;
  assign periodic_irq_request = (periodic_interval_select != rtc_alarm_pkg::PERIOD_OFF)
                              & periodic_flag;
  assign carry_irq_request    = carry_flag & carry_irq_enable;

  logic unused;
  assign unused = rd | period_other_reg[4];
endmodule // rtc_alarm_carry_irq
`default_nettype wire

// *** verification/rtc_irq_chk.sv ***
// Checker for the alarm, carry and periodic request block.
// Sees only the top module ports; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       carry_event,
  input wire logic       period_tick,
  input wire logic       alarm_irq_request,
  input wire logic       periodic_irq_request,
  input wire logic       carry_irq_request
);
  // ----------------------------------------
  // Request and bus relations
  // ----------------------------------------
  // Write access strobe; requests may only drop on one
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rst_quiet_a: assert property ($rose(presetn) |-> !alarm_irq_request && !carry_irq_request)
    else $error("request high after reset");
  carry_rise_a: assert property ($rose(carry_irq_request) |-> $past(carry_event) || $past(wr_acc))
    else $error("carry request rose without cause");
  per_rise_a: assert property ($rose(periodic_irq_request) |-> $past(period_tick) || $past(wr_acc))
    else $error("periodic request rose without cause");
  carry_fall_a: assert property ($fell(carry_irq_request) |-> $past(wr_acc))
    else $error("carry request dropped without write");
  alarm_fall_a: assert property ($fell(alarm_irq_request) |-> $past(wr_acc))
    else $error("alarm request dropped without write");
  per_fall_a: assert property ($fell(periodic_irq_request) |-> $past(wr_acc))
    else $error("periodic request dropped without write");
  bad_addr_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("no error for unmapped address");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("access not answered at once");
endmodule // rtc_irq_chk
bind rtc_alarm_carry_irq rtc_irq_chk u_chk (.*);
`default_nettype wire

// *** verification/testbench.sv ***
// Testbench: alarm, carry and periodic requests driven over APB.
// Allows the block up to 20 access cycles to answer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // Stimulus, design and helpers
  // ----------------------------------------
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [2:0] e;} row_t;
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, rd;
  logic                 pready, pslverr, er, ce = 1'b0, cr = 1'b0, pt = 1'b0, aq, pq, cq;
  rtc_alarm_pkg::time_t tc = '{16'h2024, 8'h12, 8'h31, 8'h06, 8'h23, 8'h59, 8'h45}; // count held still
  int                   err_total = 0, n_tests = 0;
  // Each field but the year alone against a fixed time, plus near misses
  row_t rows [8] = '{'{8'h0c, 32'hc5, 3'h4}, '{8'h0c, 32'hc4, 3'h0}, '{8'h10, 32'hd9, 3'h4},
    '{8'h14, 32'ha3, 3'h4}, '{8'h18, 32'h86, 3'h4}, '{8'h1c, 32'hb1, 3'h4}, '{8'h20, 32'h92, 3'h4},
    '{8'h20, 32'h91, 3'h0}};
  always #2 pclk = ~pclk;
  rtc_alarm_carry_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .time_count(tc),
    .carry_event(ce), .carry_ready(cr), .period_tick(pt), .counter_write(), .alarm_irq_request(aq),
    .periodic_irq_request(pq), .carry_irq_request(cq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; an idle edge first keeps drivers from colliding
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      end_of_test();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Requests compared together: alarm, periodic, carry; one edge lets the flag follow the match
  task automatic look(input logic [2:0] e);
    @(posedge pclk);
    @(negedge pclk);
    chk(32'({aq, pq, cq}), 32'(e));
  endtask
  // One-cycle event pulse: carry when c is high, periodic tick otherwise
  task automatic tick(input logic c);
    @(posedge pclk);
    if (c) ce <= 1'b1;
    else pt <= 1'b1;
    @(posedge pclk);
    ce <= 1'b0;
    pt <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h02);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      look(rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d);
      apb(1'b1, rows[i].a, 32'h0);
      apb(1'b1, 8'h00, 32'h02);
    end
    apb(1'b1, 8'h24, 32'h2024);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h2024);
    look(3'h0);
    apb(1'b1, 8'h08, 32'h80);
    look(3'h4);
    apb(1'b1, 8'h00, 32'h0);
    look(3'h0);
    apb(1'b1, 8'h00, 32'h02);
    look(3'h4);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    tick(1'b1);
    look(3'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, 8'h00, 32'h90);
    look(3'h1);
    apb(1'b1, 8'h00, 32'h10);
    look(3'h0);
    @(posedge pclk);
    cr <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h18);
    tick(1'b0);
    look(3'h0);
    apb(1'b1, 8'h04, 32'h90);
    look(3'h2);
    apb(1'b1, 8'h04, 32'h10);
    look(3'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    // Mid-run reset must drop both enables again
    apb(1'b1, 8'h00, 32'h12);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h08);
    look(3'h0);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
